//--- hw/analog_comparator_control.sv
// Control and status logic around one analog comparator, APB slave.
// Assumes the analog macro accepts power, hysteresis and pull-up
// disconnect levels and returns an asynchronous raw compare output.
//
// Overview of operation
// - Pin select connects comparator inputs, drops I/O
// - Pin select alone disconnects input pull-highs
// - Power bit zero switches comparator fully off
// - Polarity bit inverts raw result when set
// - Result bit read-only, follows compare and polarity
// - Path zero with pin select drives output pin
// - Otherwise output stays internal, pin is input only
// - Hysteresis bit adds positive feedback
// - Control bits two and one read zero
// - Every result change sets interrupt flag unless power goes off on that edge
// - Vector only when flag and enable set
// - Event comes from result bit, not pin
// - Flag setting in sleep or idle wakes
// - Enabled comparator keeps running while asleep
// - Shared pin in comparator use reads zero when control is one
// - Flag bit5, enable bit2, both reset zero
// - Global enable zero blocks comparator interrupt
`timescale 1ns/100ps
`default_nettype none
module analog_comparator_control #(
	parameter int SHARED_PINS = 3
) (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    raw_compare,
	input  wire logic                    cpu_sleeping,
	input  wire logic [SHARED_PINS-1:0]  pin_level,
	output logic                         comparator_power,
	output logic                         hysteresis_on,
	output logic                         comparator_inputs_sel,
	output logic                         pull_high_disconnect,
	output logic                         comparator_output_pin,
	output logic                         comparator_output_pin_oe,
	output logic                         comparator_irq_request,
	output logic                         wake_request,
	output logic [SHARED_PINS-1:0]       port_out,
	output logic [SHARED_PINS-1:0]       port_oe
);
	import cmp_ctrl_pkg::*;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	// Two input pins plus the output pin; the pin map needs all three
	if (SHARED_PINS != 3) begin : g_bad_pins
		$error("SHARED_PINS must be 3");
	end

	// ----------------------------------------
	// Registers and wires
	// ----------------------------------------
	logic [7:0]             ctrl_ff;
	logic [7:0]             nxt_ctrl;
	logic [7:0]             irqc_ff;
	logic [7:0]             nxt_irqc;
	logic [SHARED_PINS-1:0] pctl_ff;
	logic [SHARED_PINS-1:0] pdat_ff;
	logic                   result_ff;
	logic [31:0]            rdata_ff;
	logic                   slverr_ff;
	logic                   sync_raw;
	logic                   polar_res;
	logic                   flag_now;
	logic                   flag_set;
	logic                   wr_ctrl;
	logic                   wr_irqc;
	logic                   wr_pctl;
	logic                   wr_pdat;
	logic                   access;
	logic                   hit;
	logic                   cmp_active;
	logic                   pin_func;
	logic [SHARED_PINS-1:0] port_read;
	logic [31:0]            rd_mux;

	// Address match for one register offset
	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = (a == ofs);
	endfunction : wr_hit

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign access  = psel && penable;
	assign hit     = wr_hit(paddr, OFS_COMPARATOR_CONTROL) || wr_hit(paddr, OFS_IRQ_CONTROL)
		|| wr_hit(paddr, OFS_PORT_CONTROL) || wr_hit(paddr, OFS_PORT_DATA);
	assign wr_ctrl = access && pwrite && wr_hit(paddr, OFS_COMPARATOR_CONTROL);
	assign wr_irqc = access && pwrite && wr_hit(paddr, OFS_IRQ_CONTROL);
	assign wr_pctl = access && pwrite && wr_hit(paddr, OFS_PORT_CONTROL);
	assign wr_pdat = access && pwrite && wr_hit(paddr, OFS_PORT_DATA);
	assign pready  = 1'b1;
	assign prdata  = rdata_ff;
	assign pslverr = slverr_ff;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Writable bits only; result and bits two/one never stored from the bus
	assign nxt_ctrl = wr_ctrl ? (pwdata[7:0] & WMASK_COMPARATOR_CTRL) : ctrl_ff;

	assign pin_func         = ctrl_ff[BIT_PIN_FUNCTION_SELECT];
	assign cmp_active       = pin_func && ctrl_ff[BIT_COMPARATOR_POWER_ON];
	assign comparator_power = ctrl_ff[BIT_COMPARATOR_POWER_ON];
	assign hysteresis_on    = ctrl_ff[BIT_HYSTERESIS_ON];
	assign comparator_inputs_sel = pin_func;
	assign pull_high_disconnect  = pin_func;

	// ----------------------------------------
	// Result path
	// ----------------------------------------
	cmp_sync u_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in (raw_compare),
		.sync_out (sync_raw)
	);

	assign polar_res = sync_raw ^ ctrl_ff[BIT_OUTPUT_POLARITY_INVERT];

	// Result freezes while powered off, so a dead input gives no events
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			result_ff <= 1'b0;
		end else if (comparator_power) begin
			result_ff <= polar_res;
		end
	end

	// ----------------------------------------
	// Interrupt flag and request
	// ----------------------------------------
	// Edges of the stored result bit, never of the pin
	cmp_edge_flag u_flag (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.sample  (result_ff),
		.track   (comparator_power),
		.sw_we   (wr_irqc),
		.sw_val  (pwdata[BIT_COMPARATOR_IRQ_FLAG]),
		.flag    (flag_now),
		.changed (flag_set)
	);

	assign nxt_irqc = wr_irqc ? (pwdata[7:0] & WMASK_IRQ_CONTROL) : irqc_ff;

	assign comparator_irq_request = flag_now && irqc_ff[BIT_COMPARATOR_IRQ_ENABLE]
		&& irqc_ff[BIT_GLOBAL_IRQ_ENABLE];
	// Only a fresh setting wakes; a preset flag cannot set again
	assign wake_request = cpu_sleeping && flag_set && !flag_now;

	// ----------------------------------------
	// Output pin routing
	// ----------------------------------------
	assign comparator_output_pin    = result_ff;
	assign comparator_output_pin_oe = pin_func && !ctrl_ff[BIT_OUTPUT_PATH_SELECT];

	// Inputs on pins 0 and 1 lose I/O; pin 2 drives only while the comparator output is routed out
	assign port_out = pdat_ff;
	assign port_oe  = ~pctl_ff & {comparator_output_pin_oe, ~pin_func, ~pin_func};

	// ----------------------------------------
	// Shared pin read-back
	// ----------------------------------------
	// Comparator pins read zero if input-configured, else the data latch
	assign port_read[0] = pin_func ? (pctl_ff[0] ? 1'b0 : pdat_ff[0]) : pin_level[0];
	assign port_read[1] = pin_func ? (pctl_ff[1] ? 1'b0 : pdat_ff[1]) : pin_level[1];
	assign port_read[2] = comparator_output_pin_oe ? (pctl_ff[2] ? 1'b0 : pdat_ff[2]) : pin_level[2];

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	assign rd_mux =
		wr_hit(paddr, OFS_COMPARATOR_CONTROL) ?
			{24'h000000, ctrl_ff[7:5], result_ff, ctrl_ff[3:0]} :
		wr_hit(paddr, OFS_IRQ_CONTROL) ?
			{24'h000000, irqc_ff[7:6], flag_now, irqc_ff[4:0]} :
		wr_hit(paddr, OFS_PORT_CONTROL) ? {29'h0000000, pctl_ff} :
		wr_hit(paddr, OFS_PORT_DATA) ? {29'h0000000, port_read} :
		32'h00000000;

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_ff   <= RST_COMPARATOR_CONTROL;
			irqc_ff   <= RST_IRQ_CONTROL;
			pctl_ff   <= '1;
			pdat_ff   <= '0;
			rdata_ff  <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			irqc_ff   <= nxt_irqc;
			pctl_ff   <= wr_pctl ? pwdata[SHARED_PINS-1:0] : pctl_ff;
			pdat_ff   <= wr_pdat ? pwdata[SHARED_PINS-1:0] : pdat_ff;
			// Read data registered in setup so it is valid in the access cycle
			rdata_ff  <= (psel && !penable && !pwrite) ? rd_mux : rdata_ff;
			slverr_ff <= psel && !penable && !hit;
		end
	end

	// cmp_active kept for clarity of gating intent
	logic unused_ok;
	assign unused_ok = cmp_active;

endmodule : analog_comparator_control
`default_nettype wire

//--- hw/cmp_ctrl_pkg.sv
// Package for the analog comparator control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package cmp_ctrl_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_COMPARATOR_CONTROL = 8'h00;
	localparam logic [7:0] OFS_IRQ_CONTROL        = 8'h04;
	localparam logic [7:0] OFS_PORT_CONTROL       = 8'h08;
	localparam logic [7:0] OFS_PORT_DATA          = 8'h0C;

	// ----------------------------------------
	// Comparator control field positions
	// ----------------------------------------
	localparam int BIT_PIN_FUNCTION_SELECT    = 7;
	localparam int BIT_COMPARATOR_POWER_ON    = 6;
	localparam int BIT_OUTPUT_POLARITY_INVERT = 5;
	localparam int BIT_COMPARATOR_RESULT      = 4;
	localparam int BIT_OUTPUT_PATH_SELECT     = 3;
	localparam int BIT_HYSTERESIS_ON          = 0;

	// ----------------------------------------
	// Primary interrupt control field positions
	// ----------------------------------------
	localparam int BIT_COMPARATOR_IRQ_FLAG   = 5;
	localparam int BIT_COMPARATOR_IRQ_ENABLE = 2;
	localparam int BIT_GLOBAL_IRQ_ENABLE     = 0;

	// ----------------------------------------
	// Reset values and write masks
	// ----------------------------------------
	localparam logic [7:0] RST_COMPARATOR_CONTROL = 8'h81;
	localparam logic [7:0] RST_IRQ_CONTROL        = 8'h00;
	localparam logic [7:0] WMASK_COMPARATOR_CTRL  = 8'hE9;
	localparam logic [7:0] WMASK_IRQ_CONTROL      = 8'h25;

	// ----------------------------------------
	// Synchroniser depth
	// ----------------------------------------
	localparam int SYNC_STAGES = 2;

endpackage : cmp_ctrl_pkg

//--- hw/cmp_edge_flag.sv
// Sticky change-detect flag with software read/write access.
// Assumes the sample input is already synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module cmp_edge_flag (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic sample,
	input  wire logic track,
	input  wire logic sw_we,
	input  wire logic sw_val,
	output logic      flag,
	output logic      changed
);
	logic last_ff;
	logic flag_ff;
	logic nxt_flag;

	// A change is only seen while tracking; set beats software clear
	assign changed  = track && (sample != last_ff);
	assign nxt_flag = changed ? 1'b1 : (sw_we ? sw_val : flag_ff);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			last_ff <= 1'b0;
			flag_ff <= 1'b0;
		end else begin
			last_ff <= sample;
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;

endmodule : cmp_edge_flag
`default_nettype wire

//--- hw/cmp_sync.sv
// Two-stage level synchroniser for the raw comparator output.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module cmp_sync (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output logic      sync_out
);
	import cmp_ctrl_pkg::*;

	logic meta_ff;
	logic hold_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			hold_ff <= meta_ff;
		end
	end

	assign sync_out = hold_ff;

endmodule : cmp_sync
`default_nettype wire

//--- tb/analog_comparator_control_bench.sv
// Self-checking bench for the comparator control block.
// Assumes the analog model and the bound checker beside the design.
`timescale 1ns/100ps
`default_nettype none
module analog_comparator_control_bench;
	import cmp_ctrl_pkg::*;
	logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        cpu_sleeping = 0, target = 0, raw_compare, pready, pslverr;
	logic        comparator_power, hysteresis_on, comparator_inputs_sel, pull_high_disconnect;
	logic        comparator_output_pin, comparator_output_pin_oe, comparator_irq_request, wake_request;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, seed = 32'h7883;
	logic [2:0]  pin_level, port_out, port_oe;
	logic [33:0] exp_q[$], note;
	int          bad_count = 0, n_tests = 0, cycles = 0, wakes = 0;
	// ------------
	// Harness
	// ------------
	analog_comparator_control i_dut (.*);
	cmp_analog_model i_model (.*);
	initial forever #50 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// One APB transfer; the note {read, error, data} goes to the monitor
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [33:0] e);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		exp_q.push_back(e);
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 34'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
		apb(a, 1'b0, 32'h0, {1'b1, err, d});
	endtask : rd
	// Monitor: completed transfers, wake pulses and the hang limit
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 5000) begin
			bad_count++;
			test_done();
		end else begin
			if (wake_request === 1'b1)
				wakes++;
			if (psel && penable && pready === 1'b1) begin
				note = exp_q.pop_front();
				check("pslverr", note[32], pslverr);
				if (note[33])
					check("prdata", note[31:0], prdata);
			end
		end
	end
	// Main sequence; result tracked as the bench expects it
	initial begin
		logic [31:0] r;
		logic        pol, pw, pre, en, glb, res, tp, mid, chg, flag;
		int          w;
		res = 1'b0;
		tp  = 1'b0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(OFS_COMPARATOR_CONTROL, 32'h00000081, 1'b0);
		rd(OFS_IRQ_CONTROL, 32'h00000000, 1'b0);
		rd(8'h10, 32'h00000000, 1'b1);
		wr(OFS_COMPARATOR_CONTROL, 32'h000000DF);
		rd(OFS_COMPARATOR_CONTROL, 32'h000000C9, 1'b0);
		check("path enable", 32'h0, comparator_output_pin_oe);
		wr(OFS_COMPARATOR_CONTROL, 32'h000000C0);
		@(posedge clk_sys);
		check("path enable", 32'h1, comparator_output_pin_oe);
		check("hysteresis", 32'h0, hysteresis_on);
		// Random power, polarity, preset, enables, sleep and input level
		// A polarity or power change moves the result before the new input does
		repeat (16) begin
			r = xs();
			{pol, pw, pre, en, glb} = r[4:0];
			cpu_sleeping <= r[5];
			wr(OFS_IRQ_CONTROL, {26'h0, pre, 2'b0, en, 1'b0, glb});
			wr(OFS_COMPARATOR_CONTROL, {24'h0, 1'b1, pw, pol, 5'h01});
			w = wakes;
			target <= r[6];
			repeat (8) @(posedge clk_sys);
			mid = pw ? (tp ^ pol) : res;
			chg = (mid != res) || (pw && ((r[6] ^ pol) != mid));
			if (pw)
				res = r[6] ^ pol;
			tp = r[6];
			flag = pre | chg;
			rd(OFS_COMPARATOR_CONTROL, {24'h0, 1'b1, pw, pol, res, 4'h1}, 1'b0);
			rd(OFS_IRQ_CONTROL, {26'h0, flag, 2'b0, en, 1'b0, glb}, 1'b0);
			check("irq request", flag & en & glb, comparator_irq_request);
			check("wake pulses", r[5] & chg & ~pre, 32'(wakes - w));
			check("output pin", {31'h0, res}, comparator_output_pin);
			check("power", {31'h0, pw}, comparator_power);
		end
		wr(OFS_PORT_CONTROL, 32'h00000004);
		wr(OFS_PORT_DATA, 32'h00000007);
		rd(OFS_PORT_CONTROL, 32'h00000004, 1'b0);
		rd(OFS_PORT_DATA, 32'h00000003, 1'b0);
		// Comparator off and pins back to plain I/O, as before a sleep
		wr(OFS_COMPARATOR_CONTROL, 32'h00000000);
		@(posedge clk_sys);
		check("port enable", 32'h3, port_oe);
		check("port data", 32'h7, port_out);
		check("pull disconnect", 32'h0, pull_high_disconnect);
		check("input select", 32'h0, comparator_inputs_sel);
		// Pin levels step once per edge; setup samples them two edges on
		rd(OFS_PORT_DATA, {29'h0, pin_level + 3'h2}, 1'b0);
		test_done();
	end
endmodule : analog_comparator_control_bench
`default_nettype wire

//--- tb/cmp_analog_model.sv
// Analog side model: raw comparator output and shared pin levels.
// Assumes the bench sets the wanted compare level on target.
`timescale 1ns/100ps
`default_nettype none
module cmp_analog_model (
	input  wire logic       clk_sys,
	input  wire logic       target,
	output logic            raw_compare,
	output logic [2:0]      pin_level
);
	// Output settles off the clock grid, as a real comparator would
	initial raw_compare = 1'b0;
	always @(target) raw_compare <= #37 target;
	// Pin levels keep moving so a stale sample never looks valid
	initial pin_level = 3'h0;
	always @(posedge clk_sys) pin_level <= pin_level + 3'h1;
endmodule : cmp_analog_model
`default_nettype wire

//--- tb/cmp_ctrl_checker.sv
// Concurrent checks on the comparator control block's ports.
// Assumes it is bound to the block's top module.
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl_checker #(
	parameter int SHARED_PINS = 3
) (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic                   cpu_sleeping,
	input wire logic                   comparator_power,
	input wire logic                   hysteresis_on,
	input wire logic                   comparator_inputs_sel,
	input wire logic                   pull_high_disconnect,
	input wire logic                   comparator_output_pin,
	input wire logic                   comparator_output_pin_oe,
	input wire logic                   comparator_irq_request,
	input wire logic                   wake_request,
	input wire logic [SHARED_PINS-1:0] port_oe
);
	// ------------
	// Checks
	// ------------
	logic wr_acc;
	// Register writes are the only software cause of an irq change
	assign wr_acc = pwrite & penable;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	reset_vals_a: assert property ($fell(sys_rst) |-> comparator_inputs_sel && !comparator_power && hysteresis_on)
		else $error("control outputs wrong after reset");
	pull_match_a: assert property (pull_high_disconnect == comparator_inputs_sel)
		else $error("pull-high disconnect does not follow pin select");
	io_released_a: assert property (comparator_inputs_sel |-> !port_oe[0] && !port_oe[1])
		else $error("comparator input pin still driven as I/O");
	oe_needs_sel_a: assert property (comparator_output_pin_oe |-> comparator_inputs_sel)
		else $error("output pin driven with pin select off");
	frozen_off_a: assert property ($changed(comparator_output_pin) |-> $past(comparator_power))
		else $error("result moved while powered off");
	irq_cause_a: assert property ($rose(comparator_irq_request) |-> $past(wr_acc) || $past(comparator_output_pin) != $past(comparator_output_pin, 2))
		else $error("irq request rose without a result change");
	wake_pulse_a: assert property (wake_request |=> !wake_request)
		else $error("wake request longer than one cycle");
	wake_sleep_a: assert property (wake_request |-> cpu_sleeping && comparator_power)
		else $error("wake request while awake or powered off");
endmodule : cmp_ctrl_checker
bind analog_comparator_control cmp_ctrl_checker #(.SHARED_PINS(SHARED_PINS)) u_chk (.*);
`default_nettype wire
